// *** rtl/core_perf_event_decoder.sv ***
// Purpose: event selection and counting for a set of pipeline events
// Assumes: event sources synchronous to hclk; AHB-Lite register slave
// Notes: reference ticks are counted as a per-cycle amount from a 2-bit count
`timescale 1ns/1ps
`default_nettype none

module core_perf_event_decoder
  import perf_event_pkg::*;
#(
  parameter int COUNT_W = 32 // counter width
)
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, words only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // never stalls
  output logic hresp, // always okay
  input wire event_src_t events, // event sources
  output logic [COUNT_W-1:0] count_value // live counter value
);

  // ==========================================================
  // bus slave
  select_t sel_q;
  logic [COUNT_W-1:0] count_q;
  logic [31:0] rdata_q;
  logic wr_pend_q;
  logic [3:0] wr_addr_q;
  logic addr_ok;
  logic sel_valid;
  logic [4:0] amount;
  logic [4:0] amount_q;
  logic cond_q;

  assign addr_ok = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign count_value = count_q;

  // read data is captured in the address phase so it leaves a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (clk_en && addr_ok && !hwrite)
    begin
      case (haddr[3:0])
        CTRL_OFFSET: rdata_q <= 32'(sel_q);
        COUNT_OFFSET: rdata_q <= 32'(count_q);
        STATUS_OFFSET: rdata_q <= 32'({amount_q, 3'h0, sel_valid});
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 4'h0;
    end
    else if (clk_en)
    begin
      wr_pend_q <= addr_ok && hwrite && (haddr[31:4] == 28'h000_0000);
      wr_addr_q <= haddr[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sel_q <= select_t'(CTRL_RESET[$bits(select_t)-1:0]);
    end
    else if (clk_en && wr_pend_q && wr_addr_q == CTRL_OFFSET)
    begin
      sel_q <= select_t'(hwdata[$bits(select_t)-1:0]);
    end
  end

  // ==========================================================
  // event selection
  always_comb
  begin
    amount = 5'h00;
    sel_valid = 1'b1;
    case ({sel_q.code, sel_q.umask})
      {EV_WRITEBACK, UM_08}: amount = 5'(events.writeback_hit_modified);
      {EV_WRITEBACK, UM_0F}: amount = 5'(events.writeback_any_state);
      {EV_LAST_LEVEL, UM_4F}: amount = 5'(events.last_level_reference);
      {EV_LAST_LEVEL, UM_41}: amount = 5'(events.last_level_miss);
      // one per unhalted clock, so the rate tracks any throttled frequency
      {EV_CYCLES, UM_00}: amount = 5'(!events.halted);
      {EV_CYCLES, UM_01}:
        amount = events.halted ? 5'h00 : 5'(events.reference_ticks);
      {EV_PENDING_MISS, UM_01}:
      begin
        sel_valid = (sel_q.index == PENDING_COUNTER_INDEX);
        amount = sel_valid ? 5'(events.pending_data_miss_count) : 5'h00;
      end
      {EV_STORE_TLB, UM_01}: amount = 5'(events.store_walk_start);
      {EV_STORE_TLB, UM_02}: amount = 5'(events.store_walk_done);
      {EV_STORE_TLB, UM_04}: amount = 5'(events.store_walk_busy);
      {EV_STORE_TLB, UM_10}: amount = 5'(events.store_second_level_hit);
      {EV_LOAD_HIT_FILL, UM_01}: amount = 5'(events.load_hit_sw_fill);
      {EV_LOAD_HIT_FILL, UM_02}: amount = 5'(events.load_hit_hw_fill);
      {EV_LINE_FILL, UM_01}: amount = 5'(events.data_cache_line_fill);
      {EV_MOVE_ELIM, UM_04}: amount = 5'(events.move_int_kept);
      {EV_MOVE_ELIM, UM_08}: amount = 5'(events.move_simd_kept);
      {EV_MOVE_ELIM, UM_01}: amount = 5'(events.move_int_eliminated);
      {EV_MOVE_ELIM, UM_02}: amount = 5'(events.move_simd_eliminated);
      {EV_RING_CYCLES, UM_01}:
        amount = 5'(!events.halted && events.ring_zero);
      {EV_RING_CYCLES, UM_02}:
        amount = 5'(!events.halted && !events.ring_zero);
      {EV_SCHED_EMPTY, UM_01}: amount = 5'(events.scheduler_empty);
      default:
      begin
        amount = 5'h00;
        sel_valid = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // threshold and edge shaping
  logic [4:0] thresh_eff;
  logic cond;
  logic [4:0] step;

  // edge with no threshold still needs a condition, so treat it as one
  assign thresh_eff = (sel_q.edge_detect && sel_q.threshold == 4'h0) ?
                      5'h01 : 5'(sel_q.threshold);
  assign cond = (thresh_eff != 5'h00) && (amount >= thresh_eff);

  always_comb
  begin
    step = 5'h00;
    if (!sel_q.enable || !sel_valid)
      step = 5'h00;
    else if (sel_q.edge_detect)
      step = 5'(cond && !cond_q);
    else if (thresh_eff != 5'h00)
      step = 5'(cond);
    else
      step = amount;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cond_q <= 1'b0;
      amount_q <= 5'h00;
    end
    else if (clk_en)
    begin
      cond_q <= cond;
      amount_q <= amount;
    end
  end

  // ==========================================================
  // counter: a software write wins over the increment in that cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_q <= COUNT_RESET[COUNT_W-1:0];
    end
    else if (clk_en)
    begin
      if (wr_pend_q && wr_addr_q == COUNT_OFFSET)
        count_q <= hwdata[COUNT_W-1:0];
      else
        count_q <= count_q + COUNT_W'(step);
    end
  end

  // ==========================================================
  // checks
  logic write_count;
  assign write_count = wr_pend_q && wr_addr_q == COUNT_OFFSET;
  logic plain;
  logic [15:0] pair;
  assign plain = sel_q.enable && !sel_q.edge_detect &&
                 sel_q.threshold == 4'h0;
  assign pair = {sel_q.code, sel_q.umask};

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_plain_amount: assert property (
    clk_en && !write_count && sel_q.enable && sel_valid &&
    !sel_q.edge_detect && sel_q.threshold == 4'h0
    |=> count_q == $past(count_q) + COUNT_W'($past(amount)))
    else $error("counter did not add the selected amount");

  a_undefined_pair: assert property (
    clk_en && !write_count && !sel_valid |=> count_q == $past(count_q))
    else $error("undefined selection changed the counter");

  a_pending_index: assert property (
    sel_q.code == EV_PENDING_MISS && sel_q.umask == UM_01 &&
    sel_q.index != PENDING_COUNTER_INDEX |-> step == 5'h00)
    else $error("pending misses counted on wrong counter");

  a_halt_gate: assert property (
    sel_q.code == EV_CYCLES && events.halted |-> step == 5'h00)
    else $error("cycle event counted while halted");

  a_ref_ticks: assert property (
    sel_q.enable && sel_q.code == EV_CYCLES && sel_q.umask == UM_01 &&
    !events.halted && sel_q.threshold == 4'h0 && !sel_q.edge_detect
    |-> step == 5'(events.reference_ticks))
    else $error("reference ticks not counted");

  a_edge_once: assert property (
    clk_en && sel_q.edge_detect && step != 5'h00 ##1
    clk_en && $stable(sel_q) |-> step == 5'h00)
    else $error("edge counted twice in a row");

  a_threshold_one: assert property (
    sel_q.enable && sel_valid && !sel_q.edge_detect &&
    sel_q.threshold == 4'h1 |-> step == 5'(amount != 5'h00))
    else $error("threshold one is not a cycle count");

  a_ring_split: assert property (
    sel_q.code == EV_RING_CYCLES && sel_q.umask == UM_01 &&
    !events.ring_zero |-> amount == 5'h00)
    else $error("ring zero event counted outside ring zero");

  a_write_load: assert property (
    clk_en && write_count |=> count_q == $past(hwdata[COUNT_W-1:0]))
    else $error("counter write was not loaded");

  a_freeze: assert property (
    !clk_en |=> $stable(count_q) && $stable(sel_q))
    else $error("state moved with clock enable low");

  // with no shaping the step must be the raw amount of the routed source
  a_hit_modified: assert property (
    plain && pair == {EV_WRITEBACK, UM_08}
    |-> step == 5'(events.writeback_hit_modified))
    else $error("modified writebacks not counted");

  a_any_state: assert property (
    plain && pair == {EV_WRITEBACK, UM_0F}
    |-> step == 5'(events.writeback_any_state))
    else $error("writebacks in any state not counted");

  a_last_reference: assert property (
    plain && pair == {EV_LAST_LEVEL, UM_4F}
    |-> step == 5'(events.last_level_reference))
    else $error("last level references not counted");

  a_last_miss: assert property (
    plain && pair == {EV_LAST_LEVEL, UM_41}
    |-> step == 5'(events.last_level_miss))
    else $error("last level misses not counted");

  a_unhalted_cycles: assert property (
    plain && pair == {EV_CYCLES, UM_00}
    |-> step == 5'(!events.halted))
    else $error("unhalted cycles not counted");

  a_pending_count: assert property (
    plain && pair == {EV_PENDING_MISS, UM_01} &&
    sel_q.index == PENDING_COUNTER_INDEX
    |-> step == 5'(events.pending_data_miss_count))
    else $error("pending misses not added");

  a_walk_start: assert property (
    plain && pair == {EV_STORE_TLB, UM_01}
    |-> step == 5'(events.store_walk_start))
    else $error("store walk starts not counted");

  a_walk_done: assert property (
    plain && pair == {EV_STORE_TLB, UM_02}
    |-> step == 5'(events.store_walk_done))
    else $error("store walk completions not counted");

  a_walk_busy: assert property (
    plain && pair == {EV_STORE_TLB, UM_04}
    |-> step == 5'(events.store_walk_busy))
    else $error("store walk busy cycles not counted");

  a_second_level_hit: assert property (
    plain && pair == {EV_STORE_TLB, UM_10}
    |-> step == 5'(events.store_second_level_hit))
    else $error("second level store hits not counted");

  a_sw_fill_hit: assert property (
    plain && pair == {EV_LOAD_HIT_FILL, UM_01}
    |-> step == 5'(events.load_hit_sw_fill))
    else $error("software prefetch buffer hits not counted");

  a_hw_fill_hit: assert property (
    plain && pair == {EV_LOAD_HIT_FILL, UM_02}
    |-> step == 5'(events.load_hit_hw_fill))
    else $error("hardware prefetch buffer hits not counted");

  a_line_fill: assert property (
    plain && pair == {EV_LINE_FILL, UM_01}
    |-> step == 5'(events.data_cache_line_fill))
    else $error("data cache line fills not counted");

  a_int_kept: assert property (
    plain && pair == {EV_MOVE_ELIM, UM_04}
    |-> step == 5'(events.move_int_kept))
    else $error("integer moves kept not counted");

  a_simd_kept: assert property (
    plain && pair == {EV_MOVE_ELIM, UM_08}
    |-> step == 5'(events.move_simd_kept))
    else $error("vector moves kept not counted");

  a_int_eliminated: assert property (
    plain && pair == {EV_MOVE_ELIM, UM_01}
    |-> step == 5'(events.move_int_eliminated))
    else $error("integer moves eliminated not counted");

  a_simd_eliminated: assert property (
    plain && pair == {EV_MOVE_ELIM, UM_02}
    |-> step == 5'(events.move_simd_eliminated))
    else $error("vector moves eliminated not counted");

  a_ring_zero: assert property (
    plain && pair == {EV_RING_CYCLES, UM_01}
    |-> step == 5'(!events.halted && events.ring_zero))
    else $error("ring zero cycles not counted");

  a_ring_other: assert property (
    plain && pair == {EV_RING_CYCLES, UM_02}
    |-> step == 5'(!events.halted && !events.ring_zero))
    else $error("outer ring cycles not counted");

  a_sched_empty: assert property (
    plain && pair == {EV_SCHED_EMPTY, UM_01}
    |-> step == 5'(events.scheduler_empty))
    else $error("empty scheduler cycles not counted");

  c_pending_cycles: cover property (
    sel_q.code == EV_PENDING_MISS && step != 5'h00 ##1 step != 5'h00);
  c_edge_count: cover property (sel_q.edge_detect && step == 5'h01);
  c_multi_amount: cover property (step > 5'h01);
  c_count_write: cover property (write_count ##1 step != 5'h00);
  c_freeze: cover property (!clk_en ##1 clk_en);

endmodule : core_perf_event_decoder

`default_nettype wire

// *** rtl/perf_event_pkg.sv ***
// Purpose: constants and carrier types for the performance event decoder
// Assumes: AHB-Lite register access, 32-bit data, word registers
// Notes: event codes and unit masks are the hardware encodings
package perf_event_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] COUNT_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  // ==========================================================
  // control and status field positions
  localparam int CODE_LSB = 0;
  localparam int UMASK_LSB = 8;
  localparam int THRESH_LSB = 16;
  localparam int EDGE_BIT = 20;
  localparam int ENABLE_BIT = 21;
  localparam int INDEX_LSB = 22;
  localparam int VALID_BIT = 0;
  localparam int AMOUNT_LSB = 4;

  // ==========================================================
  // event codes and unit masks
  localparam logic [7:0] EV_WRITEBACK = 8'h28;
  localparam logic [7:0] EV_LAST_LEVEL = 8'h2E;
  localparam logic [7:0] EV_CYCLES = 8'h3C;
  localparam logic [7:0] EV_PENDING_MISS = 8'h48;
  localparam logic [7:0] EV_STORE_TLB = 8'h49;
  localparam logic [7:0] EV_LOAD_HIT_FILL = 8'h4C;
  localparam logic [7:0] EV_LINE_FILL = 8'h51;
  localparam logic [7:0] EV_MOVE_ELIM = 8'h58;
  localparam logic [7:0] EV_RING_CYCLES = 8'h5C;
  localparam logic [7:0] EV_SCHED_EMPTY = 8'h5E;
  localparam logic [7:0] UM_00 = 8'h00;
  localparam logic [7:0] UM_01 = 8'h01;
  localparam logic [7:0] UM_02 = 8'h02;
  localparam logic [7:0] UM_04 = 8'h04;
  localparam logic [7:0] UM_08 = 8'h08;
  localparam logic [7:0] UM_0F = 8'h0F;
  localparam logic [7:0] UM_10 = 8'h10;
  localparam logic [7:0] UM_41 = 8'h41;
  localparam logic [7:0] UM_4F = 8'h4F;
  localparam logic [1:0] PENDING_COUNTER_INDEX = 2'h2;

  // ==========================================================
  // timing: fixed reference clock, ticks arrive as a 2-bit per-cycle count
  localparam int REF_CLOCK_MHZ = 100;
  localparam int SYS_CLOCK_KHZ = 10000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] writeback_hit_modified;
    logic [1:0] writeback_any_state;
    logic [1:0] last_level_reference;
    logic [1:0] last_level_miss;
    logic halted;
    logic [1:0] reference_ticks;
    logic [3:0] pending_data_miss_count;
    logic store_walk_start;
    logic store_walk_done;
    logic store_walk_busy;
    logic store_second_level_hit;
    logic [1:0] load_hit_sw_fill;
    logic [1:0] load_hit_hw_fill;
    logic data_cache_line_fill;
    logic [1:0] move_int_eliminated;
    logic [1:0] move_simd_eliminated;
    logic [1:0] move_int_kept;
    logic [1:0] move_simd_kept;
    logic ring_zero;
    logic scheduler_empty;
  } event_src_t;

  typedef struct packed {
    logic [1:0] index;
    logic enable;
    logic edge_detect;
    logic [3:0] threshold;
    logic [7:0] umask;
    logic [7:0] code;
  } select_t;

endpackage : perf_event_pkg

// *** tb/core_perf_event_decoder_tb.sv ***
// Purpose: self-checking bench for the performance event decoder
// Assumes: zero-wait AHB-Lite slave, one clock at 10 MHz
// Notes: every burst lasts five cycles; expected counts derive from that
`timescale 1ns/1ps
`default_nettype none

module core_perf_event_decoder_tb;
  import perf_event_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, count_value;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, busy, go = 1'b0, r0 = 1'b0, hl = 1'b0, en = 1'b1;
  logic [4:0] sel = 5'h1F;
  event_src_t events;
  int n_errors = 0, total_checks = 0;
  // code, mask, source, per-cycle amount
  logic [27:0] tbl [21] = '{28'h2808003, 28'h280F013, 28'h2E4F023,
    28'h2E41033, 28'h3C001F1, 28'h3C01043, 28'h480105B, 28'h4901061,
    28'h4902071, 28'h4904081, 28'h4910091, 28'h4C010A3, 28'h4C020B3,
    28'h51010C1, 28'h58010D3, 28'h58020E3, 28'h58040F3, 28'h5808103,
    28'h5C011F1, 28'h5C021F1, 28'h5E01111};

  always #50 hclk = ~hclk;

  core_perf_event_decoder DUT (.hclk(hclk), .hresetn(hresetn),
    .clk_en(en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .events(events), .count_value(count_value));
  event_source_model src (.hclk(hclk), .hresetn(hresetn), .go(go),
    .sel(sel), .amt(4'hB), .len(8'h05), .halt_lvl(hl), .ring0_lvl(r0),
    .busy(busy), .events(events));

  // ==========================================================
  // bus and compare helpers
  task automatic check(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : check

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdchk(input string nm, input logic [3:0] a,
                       input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(nm, exp, x);
    check("hresp", 32'h0, 32'(hresp));
  endtask : rdchk

  function automatic logic [31:0] ctrl(input logic [7:0] c, u,
      input logic [3:0] t, input logic e, n, input logic [1:0] ix);
    return (32'(c) << CODE_LSB) | (32'(u) << UMASK_LSB) |
      (32'(t) << THRESH_LSB) | (32'(e) << EDGE_BIT) |
      (32'(n) << ENABLE_BIT) | (32'(ix) << INDEX_LSB);
  endfunction : ctrl

  // program, clear, fire one five-cycle burst, then read the count
  task automatic run(input string nm, input logic [31:0] ctl,
      input logic [4:0] s, input logic ring, halt, input logic [31:0] exp);
    wr(CTRL_OFFSET, ctl);
    wr(COUNT_OFFSET, 32'h0);
    sel <= s;
    r0 <= ring;
    hl <= halt;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    while (busy === 1'b1) @(posedge hclk);
    repeat (2) @(posedge hclk);
    rdchk(nm, COUNT_OFFSET, exp);
    check({nm, " live"}, exp, count_value);
  endtask : run

  // clock enable low for two burst cycles must drop exactly those two
  task automatic t_freeze;
    wr(CTRL_OFFSET, ctrl(EV_SCHED_EMPTY, UM_01, 4'h0, 1'b0, 1'b1, 2'h2));
    wr(COUNT_OFFSET, 32'h0);
    sel <= 5'h11;
    r0 <= 1'b0;
    hl <= 1'b0;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    en <= 1'b0;
    repeat (2) @(posedge hclk);
    check("frozen count", 32'h0, count_value);
    en <= 1'b1;
    while (busy === 1'b1) @(posedge hclk);
    repeat (2) @(posedge hclk);
    rdchk("count after freeze", COUNT_OFFSET, 32'h3);
    $display("test clock enable done");
  endtask : t_freeze

  // ==========================================================
  // scenarios
  task automatic t_regs;
    rdchk("ctrl reset", CTRL_OFFSET, CTRL_RESET);
    rdchk("count reset", COUNT_OFFSET, COUNT_RESET);
    wr(COUNT_OFFSET, 32'hA5C3_0F96);
    rdchk("count rw", COUNT_OFFSET, 32'hA5C3_0F96);
    wr(CTRL_OFFSET, 32'h00C0_4F2E);
    rdchk("ctrl rw", CTRL_OFFSET, 32'h00C0_4F2E);
    wr(4'hC, 32'hFFFF_FFFF);
    rdchk("unmapped", 4'hC, 32'h0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_table;
    logic [27:0] e;
    for (int i = 0; i < 21; i++)
    begin
      e = tbl[i];
      run($sformatf("count %h/%h", e[27:20], e[19:12]),
        ctrl(e[27:20], e[19:12], 4'h0, 1'b0, 1'b1, 2'h2), e[8:4],
        (e[27:20] == EV_RING_CYCLES) && (e[19:12] == UM_01), 1'b0,
        32'(e[3:0]) * 32'd5);
    end
    $display("test event table done");
  endtask : t_table

  task automatic t_halted;
    run("halted cycles", ctrl(EV_CYCLES, UM_00, 4'h0, 1'b0, 1'b1, 2'h2),
      5'h1F, 1'b0, 1'b1, 32'h0);
    run("halted ticks", ctrl(EV_CYCLES, UM_01, 4'h0, 1'b0, 1'b1, 2'h2),
      5'h04, 1'b0, 1'b1, 32'h0);
    $display("test halted done");
  endtask : t_halted

  task automatic t_refuse;
    run("pending index one", ctrl(EV_PENDING_MISS, UM_01, 4'h0, 1'b0,
      1'b1, 2'h1), 5'h05, 1'b0, 1'b0, 32'h0);
    rdchk("status invalid", STATUS_OFFSET, 32'h0);
    run("undefined pair", ctrl(EV_WRITEBACK, UM_02, 4'h0, 1'b0, 1'b1,
      2'h2), 5'h00, 1'b0, 1'b0, 32'h0);
    run("disabled", ctrl(EV_WRITEBACK, UM_08, 4'h0, 1'b0, 1'b0, 2'h2),
      5'h00, 1'b0, 1'b0, 32'h0);
    $display("test refusals done");
  endtask : t_refuse

  task automatic t_shape;
    run("pending cycles", ctrl(EV_PENDING_MISS, UM_01, 4'h1, 1'b0, 1'b1,
      2'h2), 5'h05, 1'b0, 1'b0, 32'h5);
    rdchk("status valid", STATUS_OFFSET, 32'h1);
    run("pending edges", ctrl(EV_PENDING_MISS, UM_01, 4'h1, 1'b1, 1'b1,
      2'h2), 5'h05, 1'b0, 1'b0, 32'h1);
    run("ring edges", ctrl(EV_RING_CYCLES, UM_01, 4'h0, 1'b1, 1'b1, 2'h2),
      5'h1F, 1'b1, 1'b0, 32'h1);
    run("threshold met", ctrl(EV_LAST_LEVEL, UM_4F, 4'h3, 1'b0, 1'b1,
      2'h2), 5'h02, 1'b0, 1'b0, 32'h5);
    run("threshold missed", ctrl(EV_LAST_LEVEL, UM_4F, 4'h4, 1'b0, 1'b1,
      2'h2), 5'h02, 1'b0, 1'b0, 32'h0);
    $display("test shaping done");
  endtask : t_shape

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // sequence and watchdog
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_table;
    t_halted;
    t_refuse;
    t_shape;
    t_freeze;
    report_and_stop;
  end

  // 31 runs of some 14 cycles each; generous margin
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    report_and_stop;
  end
endmodule : core_perf_event_decoder_tb
`default_nettype wire

// *** tb/event_source_model.sv ***
// Purpose: far-side model of the pipeline event sources
// Assumes: bursts are requested by the bench one at a time
// Notes: the thread idles halted between bursts, so cycle events stay quiet
`timescale 1ns/1ps
`default_nettype none

module event_source_model
  import perf_event_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic go, // start a burst
  input wire logic [4:0] sel, // source that fires, 1FH none
  input wire logic [3:0] amt, // per-cycle amount, cut to field width
  input wire logic [7:0] len, // burst length in cycles
  input wire logic halt_lvl, // halted level during a burst
  input wire logic ring0_lvl, // ring zero level during a burst
  output logic busy, // burst running
  output var event_src_t events // sources seen by the decoder
);
  logic [7:0] left_q;

  // ==========================================================
  // burst length
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      left_q <= 8'h00;
    else if (go)
      left_q <= len;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  assign busy = (left_q != 8'h00);

  // ==========================================================
  // source levels, all zero outside a burst except halted, which is held high
  always_comb
  begin
    events = '0;
    events.halted = !busy || halt_lvl;
    events.ring_zero = busy && ring0_lvl;
    if (busy)
    begin
      case (sel)
        5'h00: events.writeback_hit_modified = amt[1:0];
        5'h01: events.writeback_any_state = amt[1:0];
        5'h02: events.last_level_reference = amt[1:0];
        5'h03: events.last_level_miss = amt[1:0];
        5'h04: events.reference_ticks = amt[1:0];
        5'h05: events.pending_data_miss_count = amt;
        5'h06: events.store_walk_start = amt[0];
        5'h07: events.store_walk_done = amt[0];
        5'h08: events.store_walk_busy = amt[0];
        5'h09: events.store_second_level_hit = amt[0];
        5'h0A: events.load_hit_sw_fill = amt[1:0];
        5'h0B: events.load_hit_hw_fill = amt[1:0];
        5'h0C: events.data_cache_line_fill = amt[0];
        5'h0D: events.move_int_eliminated = amt[1:0];
        5'h0E: events.move_simd_eliminated = amt[1:0];
        5'h0F: events.move_int_kept = amt[1:0];
        5'h10: events.move_simd_kept = amt[1:0];
        5'h11: events.scheduler_empty = amt[0];
        default: ;
      endcase
    end
  end
endmodule : event_source_model
`default_nettype wire
